// ---- mag_seq_cfg.svh ----
// Constants of the magnetometer measurement sequencer
// Overview of operation
// R1: Mode 0000 power-down, 0001 single shot
// R2: Even nonzero patterns select seven periodic rates
// R3: Periodic mode runs until host rewrites mode
// R4: Reset gives power-down; valid write starts mode
// R5: Power-down keeps register contents and access
// R6: Single shot stores, then mode returns 0000
// R7: Single completion sets ready and comparator bits
// R8: Periodic mode sleeps with only period counter
// R9: New mode or threshold write ends periodic
// R10: Setting access halts updates until mode rewrite
// R11: Periodic ready set when entering power save
// R12: Ready enable drives both interrupt pins
// R13: Data read or setting access clears ready
// R14: Flags plus data read clears ready, overrun
// R15: Data access protects stored results until end
// R16: Data registers show previous result meanwhile
// R17: Unread result overrun; cleared next store
// R18: Unfinished read defers next store, no overrun
// R19: Host writes 0000 to stop periodic mode
// R20: Each store runs all threshold comparisons
// R21: Hysteresis: above operate sets, below release clears
// R22: Six channels, two per axis, 16-bit levels
// R23: Reset pin or soft bit reinitialises all
// R24: Period from internal clock; signed compares
`ifndef MAG_SEQ_CFG_SVH
`define MAG_SEQ_CFG_SVH

// Register offsets
`define ADDR_FLAGS 8'h10
`define ADDR_X_HI 8'h11
`define ADDR_Z_LO 8'h16
`define ADDR_SET_FIRST 8'h20
`define ADDR_SET_LAST 8'h27
`define ADDR_IRQ_CTRL 8'h20
`define ADDR_MODE_CTRL 8'h21
`define ADDR_SOFT_RST 8'h22
`define ADDR_THR_FIRST 8'h30
`define ADDR_THR_LAST 8'h47

// Field positions
`define FLAG_DATA_READY_FLAG_BIT 0
`define FLAG_DOR_BIT 1
`define IRQ_DATA_READY_FLAG_EN_BIT 0
`define SOFT_RST_BIT 0

// Mode patterns
`define MODE_PD 4'h0
`define MODE_SINGLE 4'h1
`define MODE_P025 4'h2
`define MODE_P05 4'h4
`define MODE_P1 4'h6
`define MODE_P10 4'h8
`define MODE_P20 4'hA
`define MODE_P50 4'hC
`define MODE_P100 4'hE

// Measurement periods in ms (0.25, 0.5, 1, 10, 20, 50, 100 Hz)
`define PERIOD_P025_MS 12'hFA0
`define PERIOD_P05_MS 12'h7D0
`define PERIOD_P1_MS 12'h3E8
`define PERIOD_P10_MS 12'h064
`define PERIOD_P20_MS 12'h032
`define PERIOD_P50_MS 12'h014
`define PERIOD_P100_MS 12'h00A

// Timing: clock rate in kHz and period tick in ms
`define CLK_FREQ_KHZ 25000
`define TICK_TIME_MS 1

// Threshold reset value and unmapped read value
`define THR_RESET 16'h0000
`define RDATA_UNMAPPED 8'h00

`endif

// ---- mag_seq_pkg.sv ----
// Types of the magnetometer measurement sequencer
package mag_seq_pkg;

	// Sequencer phases, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_MEAS = 3'b010,
		ST_SAVE = 3'b100
	} seq_state_type;

	// Register access from the serial front end
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
		logic xfer_end;
	} reg_req_type;

	// Result from the analog front end
	typedef struct packed {
		logic done;
		logic [2:0][15:0] field;
	} sample_type;

	// Comparator channel state
	typedef struct packed {
		logic result;
	} cmp_state_type;

	// Whole sequencer state
	typedef struct packed {
		seq_state_type phase;
		logic [3:0] mode;
		logic data_ready_flag_irq_en;
		logic data_ready_flag;
		logic overrun_flag;
		logic halted;
		logic rd_data;
		logic rd_flags;
		logic [2:0][15:0] field;
		logic pend;
		logic [2:0][15:0] pend_field;
		logic [5:0][15:0] operate;
		logic [5:0][15:0] release_lvl;
		logic [16:0] ms_div;
		logic [11:0] ms_left;
		logic [7:0] rdata;
		logic start;
		logic sw_update;
	} seq_regs_type;

endpackage

// ---- hysteresis_comparator.sv ----
// One hysteresis switch comparator channel
`timescale 1ns/1ps
`include "mag_seq_cfg.svh"

module hysteresis_comparator
	import mag_seq_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic clear_in,
	input wire logic update_in,
	input wire logic [15:0] data_in,
	input wire logic [15:0] operate_in,
	input wire logic [15:0] release_in,
	output logic result_out
);

	cmp_state_type cur; // Registered state
	cmp_state_type next_cur; // Next state
	logic enabled; // Operate above release

	// Judge against levels, signed
	always_comb begin
		next_cur = cur;
		enabled = $signed(operate_in) > $signed(release_in); // R21 R24
		if (clear_in) begin
			next_cur.result = 1'b0;
		end else if (update_in && enabled) begin // R20
			if ($signed(data_in) > $signed(operate_in)) begin
				next_cur.result = 1'b1; // R21
			end else if ($signed(data_in) < $signed(release_in)) begin
				next_cur.result = 1'b0; // R21
			end
		end
	end

	// State register
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign result_out = cur.result;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	a_cmp_hold: assert property ((!update_in && !clear_in) |=> $stable(result_out)) // R21
		else $error("Comparator output changed without update");

endmodule

// ---- magnetometer_measure_sequencer.sv ----
// Measurement sequencer with flags, read protection and comparators
`timescale 1ns/1ps
`include "mag_seq_cfg.svh"

module magnetometer_measure_sequencer
	import mag_seq_pkg::*;
#(
	parameter int unsigned MS_CYCLES = `CLK_FREQ_KHZ * `TICK_TIME_MS
)
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire reg_req_type reg_req_in,
	input wire sample_type sample_in,
	output logic [7:0] reg_rdata_out,
	output logic meas_start_out,
	output logic power_save_out,
	output logic irq_out,
	output logic irq_open_drain_o_out,
	output logic irq_open_drain_oe_b_out
);

	// Reset contents of the state
	function automatic seq_regs_type reset_state();
		seq_regs_type s;
		s = '0;
		s.phase = ST_IDLE;
		s.mode = `MODE_PD;
		for (int i = 0; i < 6; i++) begin
			s.operate[i] = `THR_RESET;
			s.release_lvl[i] = `THR_RESET;
		end
		return s;
	endfunction

	// Period length of a periodic mode in ms
	function automatic logic [11:0] period_ms(input logic [3:0] m);
		case (m)
			`MODE_P025: period_ms = `PERIOD_P025_MS;
			`MODE_P05: period_ms = `PERIOD_P05_MS;
			`MODE_P1: period_ms = `PERIOD_P1_MS;
			`MODE_P10: period_ms = `PERIOD_P10_MS;
			`MODE_P20: period_ms = `PERIOD_P20_MS;
			`MODE_P50: period_ms = `PERIOD_P50_MS;
			`MODE_P100: period_ms = `PERIOD_P100_MS;
			default: period_ms = 12'h000;
		endcase
	endfunction

	// Pattern names a periodic mode
	function automatic logic is_periodic(input logic [3:0] m);
		return period_ms(m) != 12'h000;
	endfunction

	localparam seq_regs_type SEQ_RESET = reset_state();
	localparam logic [16:0] DIV_LAST = 17'(MS_CYCLES - 1);

	seq_regs_type cur; // Registered state
	seq_regs_type next_cur; // Next state
	logic [5:0] sw_bits; // Comparator outputs
	logic access; // Any register access
	logic setting; // Access in setting range
	logic data_rd; // Byte read of result data
	logic tick; // One ms enable pulse
	logic soft_rst; // Soft reset request
	logic [7:0] didx; // Result byte index
	logic [7:0] tidx; // Threshold byte index
	logic [2:0] tch; // Threshold channel
	logic store_now; // Fresh result goes straight in

	assign access = reg_req_in.rd | reg_req_in.wr;
	assign setting = access && reg_req_in.addr >= `ADDR_SET_FIRST && reg_req_in.addr <= `ADDR_SET_LAST;
	assign data_rd = reg_req_in.rd && reg_req_in.addr >= `ADDR_X_HI && reg_req_in.addr <= `ADDR_Z_LO;
	assign didx = reg_req_in.addr - `ADDR_X_HI;
	assign tidx = reg_req_in.addr - `ADDR_THR_FIRST;
	assign tch = tidx[4:2];

	// Next-state logic
	always_comb begin
		next_cur = cur;
		next_cur.start = 1'b0;
		next_cur.sw_update = 1'b0;
		tick = 1'b0;
		soft_rst = 1'b0;
		store_now = 1'b0;

		// Read data, registered one cycle after the strobe
		if (reg_req_in.rd) begin
			if (reg_req_in.addr == `ADDR_FLAGS) begin
				next_cur.rdata = {sw_bits, cur.overrun_flag, cur.data_ready_flag};
			end else if (data_rd) begin
				next_cur.rdata = didx[0] ? cur.field[didx[2:1]][7:0] : cur.field[didx[2:1]][15:8]; // R16
			end else if (reg_req_in.addr == `ADDR_IRQ_CTRL) begin
				next_cur.rdata = {7'h00, cur.data_ready_flag_irq_en};
			end else if (reg_req_in.addr == `ADDR_MODE_CTRL) begin
				next_cur.rdata = {4'h0, cur.mode}; // R5
			end else if (reg_req_in.addr >= `ADDR_THR_FIRST && reg_req_in.addr <= `ADDR_THR_LAST) begin
				if (tidx[1]) begin
					next_cur.rdata = tidx[0] ? cur.release_lvl[tch][7:0] : cur.release_lvl[tch][15:8];
				end else begin
					next_cur.rdata = tidx[0] ? cur.operate[tch][7:0] : cur.operate[tch][15:8];
				end
			end else begin
				next_cur.rdata = `RDATA_UNMAPPED;
			end
		end

		// Millisecond divider, only alive in power save
		if (cur.phase == ST_SAVE) begin // R8 R24
			if (cur.ms_div == DIV_LAST) begin
				next_cur.ms_div = 17'h00000;
				tick = 1'b1;
			end else begin
				next_cur.ms_div = cur.ms_div + 17'h00001;
			end
		end else begin
			next_cur.ms_div = 17'h00000;
		end

		// Period countdown wakes a new measurement
		if (tick) begin
			if (cur.ms_left <= 12'h001) begin
				next_cur.phase = ST_MEAS; // R8
				next_cur.start = 1'b1;
			end else begin
				next_cur.ms_left = cur.ms_left - 12'h001;
			end
		end

		// Track what the current transfer has read
		if (data_rd) begin
			next_cur.rd_data = 1'b1; // R15
		end
		if (reg_req_in.rd && reg_req_in.addr == `ADDR_FLAGS) begin
			next_cur.rd_flags = 1'b1;
		end

		// Transfer end finishes a read
		if (reg_req_in.xfer_end) begin
			next_cur.rd_data = 1'b0;
			next_cur.rd_flags = 1'b0;
			if (cur.rd_data) begin
				next_cur.data_ready_flag = 1'b0; // R13
				if (cur.rd_flags) begin
					next_cur.overrun_flag = 1'b0; // R14
				end
			end
			if (cur.pend) begin
				next_cur.pend = 1'b0;
				next_cur.field = cur.pend_field; // R18
				next_cur.data_ready_flag = 1'b1;
				next_cur.overrun_flag = 1'b0; // R18
				next_cur.sw_update = 1'b1;
			end
		end

		// Measurement completion
		if (cur.phase == ST_MEAS && sample_in.done) begin
			if (cur.mode == `MODE_SINGLE) begin
				next_cur.mode = `MODE_PD; // R6
				next_cur.phase = ST_IDLE;
			end else begin
				next_cur.phase = ST_SAVE; // R8 R3
				next_cur.ms_left = period_ms(cur.mode);
			end
			if (!cur.halted && !setting) begin
				if (cur.rd_data && !reg_req_in.xfer_end) begin
					next_cur.pend = 1'b1; // R15 R18
					next_cur.pend_field = sample_in.field;
				end else begin
					store_now = 1'b1;
					next_cur.field = sample_in.field; // R6
					next_cur.overrun_flag = next_cur.data_ready_flag; // R17
					next_cur.data_ready_flag = 1'b1; // R7 R11
					next_cur.sw_update = 1'b1; // R20
				end
			end
		end

		// Setting access clears flags and halts updates
		if (setting) begin
			next_cur.data_ready_flag = 1'b0; // R13 R14
			next_cur.overrun_flag = 1'b0;
			next_cur.halted = 1'b1; // R10
			next_cur.pend = 1'b0;
			next_cur.sw_update = 1'b0;
		end

		// Register writes
		if (reg_req_in.wr) begin
			if (reg_req_in.addr == `ADDR_IRQ_CTRL) begin
				next_cur.data_ready_flag_irq_en = reg_req_in.wdata[`IRQ_DATA_READY_FLAG_EN_BIT];
			end else if (reg_req_in.addr == `ADDR_MODE_CTRL) begin
				if (reg_req_in.wdata[3:0] == `MODE_PD) begin
					next_cur.mode = `MODE_PD; // R1 R19
					next_cur.phase = ST_IDLE;
					next_cur.halted = 1'b0;
				end else if (reg_req_in.wdata[3:0] == `MODE_SINGLE || is_periodic(reg_req_in.wdata[3:0])) begin
					next_cur.mode = reg_req_in.wdata[3:0]; // R1 R2 R4 R9
					next_cur.phase = ST_MEAS;
					next_cur.start = 1'b1;
					next_cur.halted = 1'b0; // R10
				end
			end else if (reg_req_in.addr == `ADDR_SOFT_RST) begin
				soft_rst = reg_req_in.wdata[`SOFT_RST_BIT]; // R23
			end else if (reg_req_in.addr >= `ADDR_THR_FIRST && reg_req_in.addr <= `ADDR_THR_LAST) begin
				if (tidx[1]) begin
					if (tidx[0]) begin
						next_cur.release_lvl[tch][7:0] = reg_req_in.wdata;
					end else begin
						next_cur.release_lvl[tch][15:8] = reg_req_in.wdata;
					end
				end else begin
					if (tidx[0]) begin
						next_cur.operate[tch][7:0] = reg_req_in.wdata;
					end else begin
						next_cur.operate[tch][15:8] = reg_req_in.wdata;
					end
				end
				if (is_periodic(cur.mode)) begin
					next_cur.mode = `MODE_PD; // R9
					next_cur.phase = ST_IDLE;
				end
			end
		end

		// Soft reset returns everything to defaults
		if (soft_rst) begin
			next_cur = SEQ_RESET; // R23 R4
		end
	end

	// State register
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cur <= SEQ_RESET; // R23 R4
		end else begin
			cur <= next_cur;
		end
	end

	// Six comparators, two per axis, fed with the value being stored
	for (genvar ch = 0; ch < 6; ch++) begin : g_cmp
		hysteresis_comparator u_cmp (
			.clk_in(clk_in),
			.rst_b_in(rst_b_in),
			.clear_in(soft_rst),
			.update_in(next_cur.sw_update),
			.data_in(next_cur.field[ch / 2]),
			.operate_in(cur.operate[ch]),
			.release_in(cur.release_lvl[ch]),
			.result_out(sw_bits[ch])
		); // R22 R7
	end

	// Outputs
	assign reg_rdata_out = cur.rdata;
	assign meas_start_out = cur.start;
	assign power_save_out = cur.phase == ST_SAVE;
	assign irq_out = cur.data_ready_flag_irq_en & cur.data_ready_flag; // R12
	assign irq_open_drain_o_out = 1'b0;
	assign irq_open_drain_oe_b_out = ~(cur.data_ready_flag_irq_en & cur.data_ready_flag); // R12

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	a_single_done: assert property ((cur.phase == ST_MEAS && cur.mode == `MODE_SINGLE && sample_in.done && !access
		&& !cur.halted && !cur.rd_data) |=> (cur.mode == `MODE_PD && cur.phase == ST_IDLE && cur.data_ready_flag)) // R6
		else $error("Single shot did not finish into power-down");

	a_irq_pins: assert property ($rose(cur.data_ready_flag) && cur.data_ready_flag_irq_en |-> irq_out && !irq_open_drain_oe_b_out) // R12
		else $error("Ready not shown on interrupt pins");

	a_setting_clear: assert property ((setting && !soft_rst && !(reg_req_in.wr && reg_req_in.addr == `ADDR_MODE_CTRL))
		|=> (!cur.data_ready_flag && !cur.overrun_flag && cur.halted)) // R13
		else $error("Setting access left flags set");

	a_read_protect: assert property ((cur.rd_data && !reg_req_in.xfer_end && !access) |=> $stable(cur.field)) // R15
		else $error("Result changed during a read");

	a_periodic_keeps: assert property ((is_periodic(cur.mode) && !reg_req_in.wr) |=> cur.mode == $past(cur.mode)) // R3
		else $error("Periodic mode left without a write");

	a_overrun_set: assert property ((cur.phase == ST_MEAS && sample_in.done && !cur.halted && !access
		&& cur.data_ready_flag && !cur.rd_data && !reg_req_in.xfer_end) |=> (cur.overrun_flag && cur.data_ready_flag)) // R17
		else $error("Unread result did not raise overrun");

	a_deferred_store: assert property ((cur.phase == ST_MEAS && sample_in.done && !cur.halted && !access
		&& cur.rd_data && !reg_req_in.xfer_end) |=> (cur.pend && $stable(cur.field) && cur.overrun_flag == $past(cur.overrun_flag))) // R18
		else $error("Result stored over a read in progress");

	a_mode_start: assert property ((reg_req_in.wr && reg_req_in.addr == `ADDR_MODE_CTRL && !soft_rst
		&& is_periodic(reg_req_in.wdata[3:0])) |=> (meas_start_out && cur.phase == ST_MEAS ##1 !meas_start_out)) // R4
		else $error("Mode write did not start a measurement");

	a_save_wake: assert property ((cur.phase == ST_SAVE && tick && cur.ms_left == 12'h001 && !access)
		|=> (cur.phase == ST_MEAS && meas_start_out)) // R8
		else $error("Power save did not wake at period end");

endmodule

// ---- frontend_model.sv ----
// Analog front end model that answers each measurement start with one sample
`timescale 1ns/1ps
module frontend_model
	import mag_seq_pkg::*;
#(
	parameter int LATENCY = 4
)
(
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic start_in,
	input wire logic [2:0][15:0] field_in,
	output sample_type sample_out
);
	logic [3:0] count; // Cycles left to the answer
	logic done; // One-cycle answer strobe

	// Counts down from each start and strobes once at the end
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			count <= 4'h0;
			done <= 1'b0;
		end else begin
			done <= (count == 4'h1);
			if (start_in) begin
				count <= LATENCY[3:0];
			end else if (count != 4'h0) begin
				count <= count - 4'h1;
			end
		end
	end

	// Field valid only with done; inverse otherwise so stale values never match
	assign sample_out.done = done;
	assign sample_out.field = done ? field_in : ~field_in;
endmodule

// ---- magnetometer_measure_sequencer_test.sv ----
// Self-checking bench of the measurement sequencer
`timescale 1ns/1ps
module magnetometer_measure_sequencer_test;
	import mag_seq_pkg::*;
	logic clk_in = 1'b0; // Main clock
	logic rst_b_in = 1'b0; // Reset, active low
	reg_req_type req = '0; // Register requests
	sample_type smp; // Front end answer
	logic [2:0][15:0] fld = {16'h0300, 16'hFFF0, 16'h0200}; // Z, Y, X
	logic [7:0] rdata; // Read byte
	logic start, ps, irq, od_o, od_oe_b; // Design outputs
	int fail_count = 0; // Mismatches
	int tests_run = 0; // Comparisons
	int cycles = 0; // Timeout counter
	int starts = 0; // Measurement starts seen

	magnetometer_measure_sequencer #(.MS_CYCLES(4)) magnetometer_measure_sequencer_i (.clk_in(clk_in),
		.rst_b_in(rst_b_in), .reg_req_in(req), .sample_in(smp), .reg_rdata_out(rdata), .meas_start_out(start),
		.power_save_out(ps), .irq_out(irq), .irq_open_drain_o_out(od_o), .irq_open_drain_oe_b_out(od_oe_b));
	frontend_model frontend_model_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .start_in(start), .field_in(fld),
		.sample_out(smp));

	// Clock at 25 MHz
	initial begin
		forever #20 clk_in = ~clk_in;
	end

	// Hang guard and start counter
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (start === 1'b1) starts <= starts + 1;
		if (cycles == 20000) begin
			fail_count = fail_count + 1;
			end_sim();
		end
	end

	// Compare seen against expected
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h want %h", $time, seen, exp);
		end
	endtask

	// One register write
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clk_in);
		req.wr <= 1'b0;
	endtask

	// One register read, compared
	task rchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clk_in);
		req.rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask

	// End of a serial transfer
	task xfer_end();
		@(posedge clk_in);
		req.xfer_end <= 1'b1;
		@(posedge clk_in);
		req.xfer_end <= 1'b0;
	endtask

	// Wait for power save level, bounded
	task wait_ps(input logic lvl);
		for (int i = 0; i < 100 && ps !== lvl; i++) @(posedge clk_in);
		#1 chk({7'h00, ps}, {7'h00, lvl});
	endtask

	task t_reset();
		rchk(8'h10, 8'h00);
		rchk(8'h21, 8'h00);
		chk({6'h00, irq, od_oe_b}, 8'h01);
		$display("test reset done");
	endtask

	// Thresholds: ch0 +256/+128, ch1 -256/-512 so only a signed compare sets it
	task t_single();
		wr(8'h30, 8'h01);
		wr(8'h32, 8'h00);
		wr(8'h33, 8'h80);
		wr(8'h34, 8'hFF);
		wr(8'h36, 8'hFE);
		wr(8'h21, 8'h01);
		repeat (10) @(posedge clk_in);
		rchk(8'h10, 8'h0D);
		rchk(8'h11, 8'h02);
		rchk(8'h12, 8'h00);
		xfer_end();
		rchk(8'h10, 8'h0C);
		rchk(8'h21, 8'h00);
		$display("test single done");
	endtask

	task t_periodic();
		wr(8'h21, 8'h0E);
		wait_ps(1'b1);
		rchk(8'h10, 8'h0D);
		wait_ps(1'b0);
		wait_ps(1'b1);
		rchk(8'h10, 8'h0F);
		rchk(8'h15, 8'h03);
		wait_ps(1'b0);
		wait_ps(1'b1);
		xfer_end();
		rchk(8'h10, 8'h0D);
		wr(8'h21, 8'h00);
		repeat (2) @(posedge clk_in);
		starts = 0;
		repeat (80) @(posedge clk_in);
		chk(starts[7:0], 8'h00);
		chk({7'h00, ps}, 8'h00);
		$display("test periodic done");
	endtask

	task t_irq();
		wr(8'h20, 8'h01);
		wr(8'h21, 8'h01);
		for (int i = 0; i < 50 && irq !== 1'b1; i++) @(posedge clk_in);
		chk({6'h00, irq, od_oe_b}, 8'h02);
		rchk(8'h13, 8'hFF);
		rchk(8'h14, 8'hF0);
		xfer_end();
		#1 chk({6'h00, irq, od_oe_b}, 8'h01);
		$display("test irq done");
	endtask

	task t_soft();
		rchk(8'h20, 8'h01);
		wr(8'h22, 8'h01);
		@(posedge clk_in);
		rchk(8'h20, 8'h00);
		rchk(8'h10, 8'h00);
		$display("test soft reset done");
	endtask

	// Verdict and end of run
	task end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (10) @(posedge clk_in);
		rst_b_in <= 1'b1;
		t_reset();
		t_single();
		t_periodic();
		t_irq();
		t_soft();
		end_sim();
	end
endmodule
